// file: logic/mccb_pkg.sv
package mccb_pkg;
  // Build-time defaults
  localparam int DATA_W_DEF = 32;
  localparam int ADDR_W_DEF = 32;
  localparam int CMD_DEPTH_DEF = 16;
  localparam int RSP_DEPTH_DEF = 64;
  localparam int SYNC_LEN_DEF = 2;
  localparam int MAX_BURST_DEF = 8;
  localparam int DN_PENDING_DEF = 4;
  localparam bit BURST_EN_DEF = 1'b0;
  // Legal ranges
  localparam int SYNC_LEN_MIN = 2;
  localparam int SYNC_LEN_MAX = 8;
  localparam int CMD_DEPTH_MIN = 8;
  localparam int CMD_DEPTH_MAX = 32;
  localparam int RSP_DEPTH_MIN = 8;
  localparam int RSP_DEPTH_MAX = 1024;
  localparam int DATA_W_MIN = 8;
  localparam int DATA_W_MAX = 1024;
  // Reset values
  localparam logic [1:0] RST_SYNC_INIT = 2'h3;
endpackage

// file: logic/mccb_bridge.sv
module mccb_async_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8,
  parameter int WR_SYNC = 2,
  parameter int RD_SYNC = 2
) (
  // Write side
  input wire logic wrClk,
  input wire logic wrRst,
  input wire logic wrEn,
  input wire logic [W-1:0] wrData,
  output logic wrFull,
  // Read side
  input wire logic rdClk,
  input wire logic rdRst,
  input wire logic rdEn,
  output logic [W-1:0] rdData,
  output logic rdEmpty
);
  import mccb_pkg::*;
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wrBin_q, wrGray_q, rdBin_q, rdGray_q;
  logic [AW:0] wrBin_d, rdBin_d;
  logic [RD_SYNC-1:0][AW:0] wrSync_q;
  logic [WR_SYNC-1:0][AW:0] rdSync_q;
  logic wrDo, rdDo;

  assign wrDo = wrEn & ~wrFull; // R04
  assign rdDo = rdEn & ~rdEmpty; // R04
  assign wrBin_d = wrBin_q + (AW + 1)'(wrDo);
  assign rdBin_d = rdBin_q + (AW + 1)'(rdDo);

  // Write pointer, binary and gray
  always_ff @(posedge wrClk or posedge wrRst)
  begin
    if (wrRst)
    begin
      wrBin_q <= '0;
      wrGray_q <= '0;
    end
    else
    begin
      wrBin_q <= wrBin_d;
      wrGray_q <= wrBin_d ^ (wrBin_d >> 1); // R19
    end
  end

  // Storage, entries leave in arrival order
  always_ff @(posedge wrClk)
  begin
    if (wrDo)
    begin
      mem[wrBin_q[AW-1:0]] <= wrData; // R14
    end
  end

  // Read pointer, binary and gray
  always_ff @(posedge rdClk or posedge rdRst)
  begin
    if (rdRst)
    begin
      rdBin_q <= '0;
      rdGray_q <= '0;
    end
    else
    begin
      rdBin_q <= rdBin_d;
      rdGray_q <= rdBin_d ^ (rdBin_d >> 1); // R19
    end
  end

  // Gray write pointer into read domain
  always_ff @(posedge rdClk or posedge rdRst)
  begin
    if (rdRst)
    begin
      wrSync_q <= '0;
    end
    else
    begin
      wrSync_q <= {wrSync_q[RD_SYNC-2:0], wrGray_q}; // R16
    end
  end

  // Gray read pointer into write domain
  always_ff @(posedge wrClk or posedge wrRst)
  begin
    if (wrRst)
    begin
      rdSync_q <= '0;
    end
    else
    begin
      rdSync_q <= {rdSync_q[WR_SYNC-2:0], rdGray_q}; // R16
    end
  end

  assign wrFull = wrGray_q ==
    {~rdSync_q[WR_SYNC-1][AW:AW-1], rdSync_q[WR_SYNC-1][AW-2:0]}; // R04
  assign rdEmpty = rdGray_q == wrSync_q[RD_SYNC-1]; // R04
  assign rdData = mem[rdBin_q[AW-1:0]];
endmodule // mccb_async_fifo

// Contract
// R01 - Exactly two FIFOs carry traffic across domains
// R02 - Command entry holds data, address, controls, burst
// R03 - Return FIFO carries read data and valid
// R04 - No FIFO write when full, read when empty
// R05 - Pipelined ports, waitrequest and readdatavalid used
// R06 - One data width parameter sets everything
// R07 - Valid flagged per beat; busy raises waitrequest
// R08 - Queued reads return data in issue order
// R09 - Writes complete once queued, posted
// R10 - Queued transfers flow back to back
// R11 - Bursts forwarded unchanged up to maximum
// R12 - Without bursts, fabric splits bursts to singles
// R13 - Return depth covers queued bursts plus pending
// R14 - Downstream issue order equals upstream acceptance
// R15 - Command depth 8-32, return 8-1024
// R16 - Synchronizer stages per domain, 2 to 8
// R17 - Data width 8 to 1024, powers of two
// R18 - Each port on own clock, own synced reset
// R19 - Gray pointers; wait on full or no credit
// R20 - Hold command during wait; pop when free
module mccb_bridge #(
  parameter int DATA_W = mccb_pkg::DATA_W_DEF,
  parameter int ADDR_W = mccb_pkg::ADDR_W_DEF,
  parameter int CMD_DEPTH = mccb_pkg::CMD_DEPTH_DEF,
  parameter int RSP_DEPTH = mccb_pkg::RSP_DEPTH_DEF,
  parameter int US_SYNC_LEN = mccb_pkg::SYNC_LEN_DEF,
  parameter int DN_SYNC_LEN = mccb_pkg::SYNC_LEN_DEF,
  parameter bit BURST_EN = mccb_pkg::BURST_EN_DEF,
  parameter int MAX_BURST = mccb_pkg::MAX_BURST_DEF,
  parameter int DN_PENDING = mccb_pkg::DN_PENDING_DEF,
  parameter int BURST_W = $clog2(MAX_BURST) + 1
) (
  // Upstream clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Downstream clock and reset
  input wire logic dnClk,
  input wire logic dnRst,
  // Upstream slave port
  input wire logic [ADDR_W-1:0] usAddress,
  input wire logic [DATA_W-1:0] usWriteData,
  input wire logic [DATA_W/8-1:0] usByteEnable,
  input wire logic [BURST_W-1:0] usBurstCount,
  input wire logic usRead,
  input wire logic usWrite,
  output logic usWaitRequest,
  output logic [DATA_W-1:0] usReadData,
  output logic usReadDataValid,
  // Downstream master port
  output logic [ADDR_W-1:0] dnAddress,
  output logic [DATA_W-1:0] dnWriteData,
  output logic [DATA_W/8-1:0] dnByteEnable,
  output logic [BURST_W-1:0] dnBurstCount,
  output logic dnRead,
  output logic dnWrite,
  input wire logic dnWaitRequest,
  input wire logic [DATA_W-1:0] dnReadData,
  input wire logic dnReadDataValid
);
  import mccb_pkg::*;
  localparam int BE_W = DATA_W / 8;
  localparam int CMD_W = BURST_W + BE_W + ADDR_W + DATA_W + 2;
  localparam int RSP_W = DATA_W + 1;
  localparam int PEND_W = $clog2(RSP_DEPTH) + 1;

  logic [1:0] usRstSync_q, dnRstSync_q;
  logic usRst, dnRstS;
  logic cmdFull, cmdEmpty, cmdPush, cmdPop;
  logic rspFull, rspEmpty, rspPush, rspPop;
  logic [CMD_W-1:0] cmdIn, cmdOut, dnCmd_q;
  logic [RSP_W-1:0] rspIn, rspOut;
  logic [BURST_W-1:0] usLen;
  logic [PEND_W-1:0] pend_q, pend_d;
  logic [PEND_W:0] pendNeed;
  logic creditOk, usAccept, rdAccept, dnValid_q, dnLoad;
  logic [DATA_W-1:0] usReadData_q;
  logic usReadDataValid_q;

  // Reset release synced per domain
  always_ff @(posedge sys_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      usRstSync_q <= RST_SYNC_INIT;
    end
    else
    begin
      usRstSync_q <= {usRstSync_q[0], 1'h0}; // R18
    end
  end

  always_ff @(posedge dnClk or posedge dnRst)
  begin
    if (dnRst)
    begin
      dnRstSync_q <= RST_SYNC_INIT;
    end
    else
    begin
      dnRstSync_q <= {dnRstSync_q[0], 1'h0}; // R18
    end
  end

  assign usRst = usRstSync_q[1];
  assign dnRstS = dnRstSync_q[1];
  // Upstream acceptance and flow control
  assign usLen = BURST_EN ? usBurstCount : BURST_W'(1); // R11 R12
  assign pendNeed = {1'h0, pend_q} + (PEND_W + 1)'(usLen);
  assign creditOk = pendNeed <= (PEND_W + 1)'(RSP_DEPTH);
  assign usWaitRequest = cmdFull | (usRead & ~creditOk); // R07 R19 R05
  assign usAccept = (usRead | usWrite) & ~usWaitRequest; // R09
  assign rdAccept = usAccept & usRead; // R08
  assign cmdPush = usAccept;
  assign cmdIn = {usLen, usByteEnable, usAddress, usWriteData, usRead, usWrite}; // R02

  // Read words owed to upstream
  assign pend_d = pend_q + (rdAccept ? PEND_W'(usLen) : '0) - PEND_W'(rspPop);
  always_ff @(posedge sys_clk or posedge usRst)
  begin
    if (usRst)
    begin
      pend_q <= '0;
    end
    else
    begin
      pend_q <= pend_d; // R13 R19
    end
  end

  // Command FIFO, upstream to downstream
  mccb_async_fifo #(
    .W(CMD_W),
    .DEPTH(CMD_DEPTH),
    .WR_SYNC(US_SYNC_LEN),
    .RD_SYNC(DN_SYNC_LEN)
  ) cmdFifo ( // R01
    .wrClk(sys_clk),
    .wrRst(usRst),
    .wrEn(cmdPush),
    .wrData(cmdIn),
    .wrFull(cmdFull),
    .rdClk(dnClk),
    .rdRst(dnRstS),
    .rdEn(cmdPop),
    .rdData(cmdOut),
    .rdEmpty(cmdEmpty)
  );

  // Downstream output stage
  assign dnLoad = ~cmdEmpty & (~dnValid_q | ~dnWaitRequest); // R10 R20
  assign cmdPop = dnLoad;
  always_ff @(posedge dnClk or posedge dnRstS)
  begin
    if (dnRstS)
    begin
      dnValid_q <= 1'h0;
      dnCmd_q <= '0;
    end
    else if (dnLoad)
    begin
      dnValid_q <= 1'h1;
      dnCmd_q <= cmdOut; // R02 R14
    end
    else if (~dnWaitRequest)
    begin
      dnValid_q <= 1'h0; // R20
    end
  end

  assign dnWrite = dnValid_q & dnCmd_q[0];
  assign dnRead = dnValid_q & dnCmd_q[1];
  assign dnWriteData = dnCmd_q[DATA_W+1:2];
  assign dnAddress = dnCmd_q[ADDR_W+DATA_W+1:DATA_W+2];
  assign dnByteEnable = dnCmd_q[BE_W+ADDR_W+DATA_W+1:ADDR_W+DATA_W+2];
  assign dnBurstCount = dnCmd_q[CMD_W-1:CMD_W-BURST_W]; // R11

  // Return FIFO, downstream to upstream
  assign rspPush = dnReadDataValid;
  assign rspIn = {dnReadDataValid, dnReadData}; // R03
  mccb_async_fifo #(
    .W(RSP_W),
    .DEPTH(RSP_DEPTH),
    .WR_SYNC(DN_SYNC_LEN),
    .RD_SYNC(US_SYNC_LEN)
  ) rspFifo ( // R01
    .wrClk(dnClk),
    .wrRst(dnRstS),
    .wrEn(rspPush),
    .wrData(rspIn),
    .wrFull(rspFull),
    .rdClk(sys_clk),
    .rdRst(usRst),
    .rdEn(rspPop),
    .rdData(rspOut),
    .rdEmpty(rspEmpty)
  );

  // Upstream read return
  assign rspPop = ~rspEmpty;
  always_ff @(posedge sys_clk or posedge usRst)
  begin
    if (usRst)
    begin
      usReadData_q <= '0;
      usReadDataValid_q <= 1'h0;
    end
    else
    begin
      usReadData_q <= rspOut[DATA_W-1:0];
      usReadDataValid_q <= rspPop & rspOut[DATA_W]; // R07 R03
    end
  end
  assign usReadData = usReadData_q;
  assign usReadDataValid = usReadDataValid_q;

  // Checks
  AST_PARAMS: assert property (@(posedge sys_clk) disable iff (usRst) // R15 R16 R17 R06
    (CMD_DEPTH >= CMD_DEPTH_MIN) && (CMD_DEPTH <= CMD_DEPTH_MAX)
    && (RSP_DEPTH >= RSP_DEPTH_MIN) && (RSP_DEPTH <= RSP_DEPTH_MAX)
    && (DATA_W >= DATA_W_MIN) && (DATA_W <= DATA_W_MAX)
    && ((DATA_W & (DATA_W - 1)) == 0) && ((RSP_DEPTH & (RSP_DEPTH - 1)) == 0)
    && ((CMD_DEPTH & (CMD_DEPTH - 1)) == 0)
    && (US_SYNC_LEN >= SYNC_LEN_MIN) && (US_SYNC_LEN <= SYNC_LEN_MAX)
    && (DN_SYNC_LEN >= SYNC_LEN_MIN) && (DN_SYNC_LEN <= SYNC_LEN_MAX))
    else $error("Bridge parameters out of range");
  AST_RSP_DEPTH: assert property (@(posedge sys_clk) disable iff (usRst) // R13
    !BURST_EN || (RSP_DEPTH >= CMD_DEPTH * MAX_BURST + DN_PENDING))
    else $error("Return FIFO too shallow for bursts");
  AST_CMD_NO_OVF: assert property (@(posedge sys_clk) disable iff (usRst) // R04
    cmdFull |=> cmdFifo.wrBin_q == $past(cmdFifo.wrBin_q))
    else $error("Command accepted while FIFO full");
  AST_RSP_NO_OVF: assert property (@(posedge dnClk) disable iff (dnRstS) // R04
    rspPush |-> !rspFull)
    else $error("Read data arrived with return FIFO full");
  AST_PEND_BOUND: assert property (@(posedge sys_clk) disable iff (usRst) // R19
    rdAccept |=> pend_q <= PEND_W'(RSP_DEPTH) && pend_q != '0)
    else $error("Owed read count out of bounds");
  AST_WRITE_POSTED: assert property (@(posedge sys_clk) disable iff (usRst) // R09
    usWrite && !usRead && !cmdFull |-> !usWaitRequest)
    else $error("Write stalled with room in command FIFO");
  AST_DN_HOLD: assert property (@(posedge dnClk) disable iff (dnRstS) // R20
    dnValid_q && dnWaitRequest |=> dnValid_q && $stable(dnCmd_q))
    else $error("Downstream command changed during wait");
  AST_BACK_TO_BACK: assert property (@(posedge dnClk) disable iff (dnRstS) // R10
    dnValid_q && !dnWaitRequest && !cmdEmpty |=> dnValid_q && $past(cmdOut) == dnCmd_q)
    else $error("Gap between queued downstream commands");
  AST_RDV_FOLLOW: assert property (@(posedge sys_clk) disable iff (usRst) // R07 R08
    rspPop |=> usReadDataValid && usReadData == $past(rspOut[DATA_W-1:0]))
    else $error("Returned read word not presented");
  AST_CREDIT: assert property (@(posedge sys_clk) disable iff (usRst) // R19
    usRead && !creditOk |-> usWaitRequest)
    else $error("Read accepted without return space");
  COV_WRITE: cover property (@(posedge sys_clk) disable iff (usRst)
    usWrite && !usWaitRequest ##1 usWrite && !usWaitRequest);
  COV_READ_RETURN: cover property (@(posedge sys_clk) disable iff (usRst)
    rdAccept ##[1:60] usReadDataValid);
  COV_DN_STALL: cover property (@(posedge dnClk) disable iff (dnRstS)
    dnValid_q && dnWaitRequest ##1 dnValid_q && !dnWaitRequest);
  COV_CMD_FULL: cover property (@(posedge sys_clk) disable iff (usRst) cmdFull);
endmodule // mccb_bridge

// file: tb/mccb_slave_model.sv
module mccb_slave_model (
  // Clock and reset
  input wire logic dnClk,
  input wire logic dnRst,
  // Command from bridge
  input wire logic [31:0] dnAddress,
  input wire logic [31:0] dnWriteData,
  input wire logic [3:0] dnByteEnable,
  input wire logic [3:0] dnBurstCount,
  input wire logic dnRead,
  input wire logic dnWrite,
  // Response to bridge
  output logic dnWaitRequest,
  output logic [31:0] dnReadData,
  output logic dnReadDataValid,
  // Bench control and status
  input wire logic stall,
  output int wrCount,
  output logic bad
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] mem [16];
  logic [31:0] pendD_q;
  logic pendV_q;
  logic held_q;
  logic [65:0] prev_q;
  logic take;
  assign dnWaitRequest = stall;
  assign take = (dnRead | dnWrite) & ~dnWaitRequest;
  always_ff @(posedge dnClk or posedge dnRst)
  begin
    if (dnRst)
    begin
      pendV_q <= 1'b0;
      pendD_q <= 32'h0000_0000;
      dnReadDataValid <= 1'b0;
      dnReadData <= 32'h0000_0000;
      wrCount <= 0;
      bad <= 1'b0;
      held_q <= 1'b0;
      prev_q <= '0;
    end
    else
    begin
      pendV_q <= take & dnRead;
      pendD_q <= mem[dnAddress[5:2]];
      dnReadDataValid <= pendV_q;
      dnReadData <= pendV_q ? pendD_q : ~dnReadData;
      if (take & dnWrite)
      begin
        for (int b = 0; b < 4; b++)
          if (dnByteEnable[b]) mem[dnAddress[5:2]][8*b +: 8] <= dnWriteData[8*b +: 8];
        wrCount <= wrCount + 1;
      end
      if (take && dnBurstCount !== 4'h1) bad <= 1'b1;
      if (held_q && {dnRead, dnWrite, dnAddress, dnWriteData} !== prev_q) bad <= 1'b1;
      held_q <= (dnRead | dnWrite) & dnWaitRequest;
      prev_q <= {dnRead, dnWrite, dnAddress, dnWriteData};
    end
  end
endmodule // mccb_slave_model

// file: tb/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import mccb_pkg::*;
  typedef struct packed {logic [31:0] addr; logic [31:0] data; logic [3:0] be; logic [31:0] want;} mccb_row_s;
  logic sys_clk = 0, sys_rst = 1, dnClk = 0, dnRst = 1, stall = 0;
  logic usRead = 0, usWrite = 0, usWaitRequest, usReadDataValid;
  logic [31:0] usAddress = 0, usWriteData = 0, usReadData;
  logic [3:0] usByteEnable = 0, dnByteEnable, dnBurstCount;
  logic [31:0] dnAddress, dnWriteData, dnReadData;
  logic dnRead, dnWrite, dnWaitRequest, dnReadDataValid, bad;
  int wrCount, err_total = 0, total_checks = 0, cyc = 0, n;
  logic [31:0] rdQ [$];
  time tv [$];
  mccb_row_s rows [6] = '{
    '{32'h0000_0000, 32'h1111_1111, 4'hF, 32'h1111_1111},
    '{32'h0000_0004, 32'h2222_2222, 4'hF, 32'h2222_2222},
    '{32'h0000_0008, 32'h3333_3333, 4'hF, 32'h3333_A5A5},
    '{32'h0000_000C, 32'h4444_4444, 4'hF, 32'h4444_4444},
    '{32'h0000_0008, 32'h5A5A_A5A5, 4'h3, 32'h3333_A5A5},
    '{32'h0000_0010, 32'h6666_6666, 4'hF, 32'h6666_6666}};
  always #5 sys_clk = ~sys_clk;
  always #3.5 dnClk = ~dnClk;
  mccb_bridge dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .dnClk(dnClk), .dnRst(dnRst),
    .usAddress(usAddress), .usWriteData(usWriteData), .usByteEnable(usByteEnable),
    .usBurstCount(4'h1), .usRead(usRead), .usWrite(usWrite), .usWaitRequest(usWaitRequest),
    .usReadData(usReadData), .usReadDataValid(usReadDataValid), .dnAddress(dnAddress),
    .dnWriteData(dnWriteData), .dnByteEnable(dnByteEnable), .dnBurstCount(dnBurstCount),
    .dnRead(dnRead), .dnWrite(dnWrite), .dnWaitRequest(dnWaitRequest),
    .dnReadData(dnReadData), .dnReadDataValid(dnReadDataValid));
  mccb_slave_model far (.dnClk(dnClk), .dnRst(dnRst), .dnAddress(dnAddress),
    .dnWriteData(dnWriteData), .dnByteEnable(dnByteEnable), .dnBurstCount(dnBurstCount),
    .dnRead(dnRead), .dnWrite(dnWrite), .dnWaitRequest(dnWaitRequest),
    .dnReadData(dnReadData), .dnReadDataValid(dnReadDataValid), .stall(stall),
    .wrCount(wrCount), .bad(bad));
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      err_total++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Waits for acceptance, holding the request
  task automatic acc();
    int k;
    k = 0;
    do
    begin
      @(negedge sys_clk);
      k++;
    end
    while (usWaitRequest !== 1'b0 && k < 300);
    chk(usWaitRequest === 1'b0, "request never accepted");
    @(posedge sys_clk);
  endtask
  task automatic busCycle(input logic rd, input logic [31:0] a, input logic [31:0] d,
    input logic [3:0] be);
    usRead <= rd;
    usWrite <= ~rd;
    usAddress <= a;
    usWriteData <= d;
    usByteEnable <= be;
    acc();
  endtask
  always @(negedge sys_clk)
  begin
    if (usReadDataValid === 1'b1)
    begin
      rdQ.push_back(usReadData);
      tv.push_back($time);
    end
  end
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      conclude();
    end
  end
  initial
  begin
    repeat (4) @(posedge sys_clk);
    chk(usReadDataValid === 1'b0 && dnRead === 1'b0 && dnWrite === 1'b0, "reset outputs");
    chk(usWaitRequest === 1'b0, "reset wait");
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    dnRst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    // Fill command queue with far side stalled
    stall <= 1'b1;
    usWrite <= 1'b1;
    usAddress <= 32'h0000_003C;
    usByteEnable <= 4'hF;
    n = 0;
    repeat (40)
    begin
      @(negedge sys_clk);
      if (usWaitRequest === 1'b1) break;
      @(posedge sys_clk);
      n++;
    end
    chk(n >= CMD_DEPTH_DEF && n <= CMD_DEPTH_DEF + 2, "queue full point");
    chk(wrCount === 0, "write leaked while stalled");
    @(posedge sys_clk);
    stall <= 1'b0;
    acc();
    n++;
    usWrite <= 1'b0;
    for (int k = 0; k < 500 && wrCount != n; k++) @(posedge sys_clk);
    chk(wrCount === n, "stalled writes not drained");
    // Posted writes while stalled, then drain
    for (int i = 0; i < 6; i++)
    begin
      if (i == 0) stall <= 1'b1;
      busCycle(1'b0, rows[i].addr, rows[i].data, rows[i].be);
    end
    usWrite <= 1'b0;
    chk(wrCount === n, "posted writes complete early");
    stall <= 1'b0;
    for (int k = 0; k < 500 && wrCount != n + 6; k++) @(posedge sys_clk);
    chk(wrCount === n + 6, "writes lost");
    // Back-to-back reads, in-order return
    for (int i = 0; i < 6; i++)
      busCycle(1'b1, rows[i].addr, 32'h0000_0000, 4'hF);
    usRead <= 1'b0;
    for (int k = 0; k < 500 && rdQ.size() < 6; k++) @(posedge sys_clk);
    chk(rdQ.size() === 6, "read count");
    for (int i = 0; i < 6 && i < rdQ.size(); i++)
      chk(rdQ[i] === rows[i].want, "read data");
    if (tv.size() == 6) chk(tv[5] - tv[0] <= 120, "return throughput");
    chk(bad === 1'b0, "held command or burst count");
    conclude();
  end
endmodule // testbench
